// file: inc/vhr_pkg.sv
// Purpose: shared constants for the horizontal vector reduction unit
// Assumes: 256-bit vector, one predicate bit per byte, core_clk domain
// Notes:   element sizes coded 0..3 for 8/16/32/64 bits
// How it works
// - only predicate-active lanes combine into one scalar
// - ordered fp sum seeds from scalar, ascending lanes
// - ordered fp sum skips inactive lanes untouched
// - other fp reductions use pairwise tree
// - integer reductions combine in any order
// - and_reduce inactive lanes are all ones
// - xor_reduce inactive lanes are zero
// - or_reduce inactive lanes are zero
// - fp_tree_sum inactive lanes are +0.0
// - fp_max_number_reduce inactive lanes are default NaN
// - fp_max_reduce inactive lanes are negative infinity
// - fp_min_number_reduce inactive lanes are default NaN
// - fp_min_reduce inactive lanes are positive infinity
// - signed_sum_reduce inactive lanes are zero
// - signed_max_reduce inactive lanes are most negative
// - signed_min_reduce inactive lanes are most positive
// - unsigned_sum_reduce inactive lanes are zero
// - unsigned_max_reduce inactive lanes are zero
// - unsigned_min_reduce inactive lanes are all ones
package vhr_pkg;
   localparam int VEC_W    = 256;  // source vector width
   localparam int PRED_W   = 32;   // one predicate bit per byte
   localparam int LANES    = 32;   // lanes at 8-bit elements
   localparam int LEVELS   = 5;    // tree levels for 32 lanes
   localparam int SIGN_POS = 55;   // hidden bit position in fp adder
   // element size codes
   localparam logic [1:0] ESZ_8  = 2'h0;
   localparam logic [1:0] ESZ_16 = 2'h1;
   localparam logic [1:0] ESZ_32 = 2'h2;
   localparam logic [1:0] ESZ_64 = 2'h3;
   // fp field widths per format
   localparam int H_FRAC = 10;
   localparam int H_EXP  = 5;
   localparam int S_FRAC = 23;
   localparam int S_EXP  = 8;
   localparam int D_FRAC = 52;
   localparam int D_EXP  = 11;
   // fp special encodings per format
   localparam logic [63:0] H_INF  = 64'h0000_0000_0000_7C00;
   localparam logic [63:0] S_INF  = 64'h0000_0000_7F80_0000;
   localparam logic [63:0] D_INF  = 64'h7FF0_0000_0000_0000;
   localparam logic [63:0] H_DNAN = 64'h0000_0000_0000_7E00;
   localparam logic [63:0] S_DNAN = 64'h0000_0000_7FC0_0000;
   localparam logic [63:0] D_DNAN = 64'h7FF8_0000_0000_0000;
   // reset values
   localparam logic [63:0] RESULT_RST = 64'h0;
   // reduction operations
   typedef enum logic [3:0] {
      OP_AND    = 4'h0,  // and_reduce
      OP_OR     = 4'h1,  // or_reduce
      OP_XOR    = 4'h2,  // xor_reduce
      OP_SADD   = 4'h3,  // signed_sum_reduce
      OP_UADD   = 4'h4,  // unsigned_sum_reduce
      OP_SMAX   = 4'h5,  // signed_max_reduce
      OP_SMIN   = 4'h6,  // signed_min_reduce
      OP_UMAX   = 4'h7,  // unsigned_max_reduce
      OP_UMIN   = 4'h8,  // unsigned_min_reduce
      OP_FSUM   = 4'h9,  // fp_tree_sum
      OP_FSEQ   = 4'hA,  // fp_ordered_accumulate_sum
      OP_FMAX   = 4'hB,  // fp_max_reduce
      OP_FMIN   = 4'hC,  // fp_min_reduce
      OP_FMAXNM = 4'hD,  // fp_max_number_reduce
      OP_FMINNM = 4'hE   // fp_min_number_reduce
   } vhr_op_e;
   // engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TREE = 2'b01,
      ST_SEQ  = 2'b10
   } vhr_state_e;
endpackage : vhr_pkg

// file: design/vhr_reduce.sv
// Purpose: horizontal reduction of one predicated vector to a scalar
// Assumes: requests come from core_clk logic
// Notes:   fp ops at 8-bit size run as 16-bit
`timescale 1ns/100ps
`default_nettype none
module vhr_reduce (
   input  wire logic         core_clk,   // core clock, 125 MHz
   input  wire logic         rst_n,      // async reset, active low
   input  wire logic         start,      // request strobe
   input  wire logic [3:0]   op,         // reduction operation
   input  wire logic [1:0]   esz,        // element size code
   input  wire logic [255:0] src_vec,    // source vector
   input  wire logic [31:0]  pred,       // governing predicate
   input  wire logic [63:0]  scalar_in,  // seed for ordered sum
   output logic              busy,       // engine working
   output logic              done,       // result valid pulse
   output logic [63:0]       result      // scalar result
);
   // engine state
   vhr_pkg::vhr_state_e state, next_state;
   logic [3:0]  cur_op, next_op;             // latched op
   logic [1:0]  cur_esz, next_esz;           // latched size
   logic [63:0] work [0:31];                 // lane values
   logic [63:0] next_work [0:31];
   logic [31:0] act, next_act;               // active lanes
   logic [63:0] acc, next_acc;               // ordered accumulator
   logic [4:0]  idx, next_idx;               // ordered lane pointer
   logic [2:0]  lvl, next_lvl;               // tree levels left
   logic [63:0] next_result;
   logic        next_done;

   // width mask of an element
   function automatic logic [63:0] msk(input logic [1:0] s);
      unique case (s)
         vhr_pkg::ESZ_8:  msk = 64'h0000_0000_0000_00FF;
         vhr_pkg::ESZ_16: msk = 64'h0000_0000_0000_FFFF;
         vhr_pkg::ESZ_32: msk = 64'h0000_0000_FFFF_FFFF;
         vhr_pkg::ESZ_64: msk = 64'hFFFF_FFFF_FFFF_FFFF;
      endcase
   endfunction : msk

   // sign extend an element to 64 bits
   function automatic logic [63:0] sext(input logic [63:0] v, input logic [1:0] s);
      logic [63:0] m;
      m = msk(s);
      sext = ((v & ~(m >> 1)) != 64'h0) ? (v | ~m) : v;
   endfunction : sext

   // fp fraction width, 8-bit size falls back to half
   function automatic int fw_of(input logic [1:0] s);
      fw_of = (s == vhr_pkg::ESZ_64) ? vhr_pkg::D_FRAC :
              (s == vhr_pkg::ESZ_32) ? vhr_pkg::S_FRAC : vhr_pkg::H_FRAC;
   endfunction : fw_of

   // fp exponent width
   function automatic int xw_of(input logic [1:0] s);
      xw_of = (s == vhr_pkg::ESZ_64) ? vhr_pkg::D_EXP :
              (s == vhr_pkg::ESZ_32) ? vhr_pkg::S_EXP : vhr_pkg::H_EXP;
   endfunction : xw_of

   // positive infinity per format
   function automatic logic [63:0] inf_of(input logic [1:0] s);
      inf_of = (s == vhr_pkg::ESZ_64) ? vhr_pkg::D_INF :
               (s == vhr_pkg::ESZ_32) ? vhr_pkg::S_INF : vhr_pkg::H_INF;
   endfunction : inf_of

   // default nan per format
   function automatic logic [63:0] dnan_of(input logic [1:0] s);
      dnan_of = (s == vhr_pkg::ESZ_64) ? vhr_pkg::D_DNAN :
                (s == vhr_pkg::ESZ_32) ? vhr_pkg::S_DNAN : vhr_pkg::H_DNAN;
   endfunction : dnan_of

   // any nan, quiet or signalling
   function automatic logic is_nan(input logic [63:0] v, input logic [1:0] s);
      is_nan = (v & (msk(s) >> 1)) > inf_of(s);
   endfunction : is_nan

   // ordered less-than, -0 below +0
   function automatic logic flt(input logic [63:0] a, b, input logic [1:0] s);
      logic [63:0] ma, mb;
      logic        sa, sb;
      ma = a & (msk(s) >> 1);
      mb = b & (msk(s) >> 1);
      sa = (a & ~(msk(s) >> 1) & msk(s)) != 64'h0;
      sb = (b & ~(msk(s) >> 1) & msk(s)) != 64'h0;
      if (sa != sb)
         flt = sa;
      else
         flt = sa ? (ma > mb) : (ma < mb);
   endfunction : flt

   // fp min/max, number forms drop a single nan
   function automatic logic [63:0] fp_mm(input logic [63:0] a, b, input logic [1:0] s,
                                         input logic mx, num);
      logic na, nb;
      na = is_nan(a, s);
      nb = is_nan(b, s);
      if (na && nb)
         fp_mm = dnan_of(s);
      else if (na)
         fp_mm = num ? b : dnan_of(s);
      else if (nb)
         fp_mm = num ? a : dnan_of(s);
      else
         fp_mm = (mx ^ flt(a, b, s)) ? a : b;
   endfunction : fp_mm

   // fp add, round to nearest even, nan results are default nan
   function automatic logic [63:0] fp_add(input logic [63:0] a, b, input logic [1:0] s);
      int          fw, xw;
      logic [11:0] ea, eb, emax, d;
      logic [63:0] ma, mb, t, lsb, keep, tmp;
      logic        sa, sb, rb, st;
      fw   = fw_of(s);
      xw   = xw_of(s);
      emax = 12'((64'h1 << xw) - 64'h1);
      sa   = a[fw + xw];
      sb   = b[fw + xw];
      ea   = 12'((a >> fw) & 64'(emax));
      eb   = 12'((b >> fw) & 64'(emax));
      ma   = a & ((64'h1 << fw) - 64'h1);
      mb   = b & ((64'h1 << fw) - 64'h1);
      if (is_nan(a, s) || is_nan(b, s))
         return dnan_of(s);
      // infinities
      if (ea == emax)
         return (eb == emax && sa != sb) ? dnan_of(s) : a;
      if (eb == emax)
         return b;
      // hidden bit to the top, subnormals get exponent one
      ma = (ma | ((ea != 12'h0) ? (64'h1 << fw) : 64'h0)) << (vhr_pkg::SIGN_POS - fw);
      mb = (mb | ((eb != 12'h0) ? (64'h1 << fw) : 64'h0)) << (vhr_pkg::SIGN_POS - fw);
      if (ea == 12'h0) ea = 12'h1;
      if (eb == 12'h0) eb = 12'h1;
      // larger magnitude into a
      if ({ea, ma} < {eb, mb}) begin
         tmp = ma; ma = mb; mb = tmp;
         d = ea; ea = eb; eb = d;
         rb = sa; sa = sb; sb = rb;
      end
      d = ea - eb;
      // align with sticky
      t = (mb >> d) | ((mb & ((64'h1 << d) - 64'h1)) != 64'h0 ? 64'h1 : 64'h0);
      ma = (sa == sb) ? (ma + t) : (ma - t);
      if (ma == 64'h0)
         return (sa && sb) ? (64'h1 << (fw + xw)) : 64'h0;
      if (ma[56]) begin
         ma = (ma >> 1) | {63'h0, ma[0]};
         ea = ea + 12'h1;
      end
      // normalise, stopping at the subnormal floor
      for (int k = 0; k < 56; k++) begin
         if (!ma[55] && ea > 12'h1) begin
            ma = ma << 1;
            ea = ea - 12'h1;
         end
      end
      lsb  = 64'h1 << (vhr_pkg::SIGN_POS - fw);
      rb   = (ma & (lsb >> 1)) != 64'h0;
      st   = (ma & ((lsb >> 1) - 64'h1)) != 64'h0;
      keep = ma & ~(lsb - 64'h1);
      if (rb && (st || (ma & lsb) != 64'h0))
         keep = keep + lsb;
      if (keep[56]) begin
         keep = keep >> 1;
         ea   = ea + 12'h1;
      end
      // overflow to infinity
      if (ea >= emax)
         return (64'(sa) << (fw + xw)) | inf_of(s);
      if (!keep[55])
         ea = 12'h0;
      tmp = (keep >> (vhr_pkg::SIGN_POS - fw)) & ((64'h1 << fw) - 64'h1);
      return (64'(sa) << (fw + xw)) | (64'(ea) << fw) | tmp;
   endfunction : fp_add

   // identity value substituted for an inactive lane
   function automatic logic [63:0] ident(input logic [3:0] o, input logic [1:0] s);
      unique case (o)
         vhr_pkg::OP_AND:    ident = msk(s);
         vhr_pkg::OP_XOR:    ident = 64'h0;
         vhr_pkg::OP_OR:     ident = 64'h0;
         vhr_pkg::OP_FSUM:   ident = 64'h0;
         vhr_pkg::OP_FMAXNM: ident = dnan_of(s);
         vhr_pkg::OP_FMAX:   ident = inf_of(s) | ~(msk(s) >> 1) & msk(s);
         vhr_pkg::OP_FMINNM: ident = dnan_of(s);
         vhr_pkg::OP_FMIN:   ident = inf_of(s);
         vhr_pkg::OP_SADD:   ident = 64'h0;
         vhr_pkg::OP_SMAX:   ident = ~(msk(s) >> 1);
         vhr_pkg::OP_SMIN:   ident = msk(s) >> 1;
         vhr_pkg::OP_UADD:   ident = 64'h0;
         vhr_pkg::OP_UMAX:   ident = 64'h0;
         vhr_pkg::OP_UMIN:   ident = msk(s);
         default:            ident = 64'h0;                       // unused code
      endcase
   endfunction : ident

   // pairwise combine, associative for integers
   function automatic logic [63:0] comb(input logic [3:0] o, input logic [1:0] s,
                                        input logic [63:0] a, b);
      unique case (o)
         vhr_pkg::OP_AND:    comb = a & b;
         vhr_pkg::OP_OR:     comb = a | b;
         vhr_pkg::OP_XOR:    comb = a ^ b;
         vhr_pkg::OP_SADD,
         vhr_pkg::OP_UADD:   comb = a + b;
         vhr_pkg::OP_SMAX:   comb = ($signed(a) > $signed(b)) ? a : b;
         vhr_pkg::OP_SMIN:   comb = ($signed(a) < $signed(b)) ? a : b;
         vhr_pkg::OP_UMAX:   comb = (a > b) ? a : b;
         vhr_pkg::OP_UMIN:   comb = (a < b) ? a : b;
         vhr_pkg::OP_FSUM:   comb = fp_add(a, b, s);
         vhr_pkg::OP_FMAX:   comb = fp_mm(a, b, s, 1'b1, 1'b0);
         vhr_pkg::OP_FMIN:   comb = fp_mm(a, b, s, 1'b0, 1'b0);
         vhr_pkg::OP_FMAXNM: comb = fp_mm(a, b, s, 1'b1, 1'b1);
         vhr_pkg::OP_FMINNM: comb = fp_mm(a, b, s, 1'b0, 1'b1);
         default:            comb = a;                            // unused code
      endcase
   endfunction : comb

   // final width: integer sums stay 64 bits, others trimmed to the element
   function automatic logic [63:0] trim(input logic [3:0] o, input logic [1:0] s,
                                        input logic [63:0] v);
      trim = (o == vhr_pkg::OP_SADD || o == vhr_pkg::OP_UADD) ? v : (v & msk(s));
   endfunction : trim

   // next-state logic for the whole engine
   always_comb begin
      logic [63:0] raw;
      logic        pa;
      logic [63:0] sum;
      int          ew;
      logic [1:0]  se;  // fp at 8 bits runs as 16
      raw         = 64'h0;
      pa          = 1'b0;
      sum         = 64'h0;
      se          = (op >= vhr_pkg::OP_FSUM && esz == vhr_pkg::ESZ_8) ? vhr_pkg::ESZ_16 : esz;
      ew          = 8 << se;
      next_state  = state;
      next_op     = cur_op;
      next_esz    = cur_esz;
      next_act    = act;
      next_acc    = acc;
      next_idx    = idx;
      next_lvl    = lvl;
      next_result = result;
      next_done   = 1'b0;
      for (int i = 0; i < vhr_pkg::LANES; i++)
         next_work[i] = work[i];
      unique case (state)
         vhr_pkg::ST_IDLE: begin
            if (start) begin
               next_op  = op;
               next_esz = se;
               // load lanes, inactive and unused ones get the identity
               for (int i = 0; i < vhr_pkg::LANES; i++) begin
                  raw = 64'(src_vec >> (i * ew)) & msk(se);
                  pa  = ((i * ew) < vhr_pkg::VEC_W) && pred[(i * (ew / 8)) % vhr_pkg::PRED_W];
                  if (op == vhr_pkg::OP_SMAX || op == vhr_pkg::OP_SMIN ||
                      op == vhr_pkg::OP_SADD)
                     raw = sext(raw, se);
                  next_act[i]  = pa;
                  next_work[i] = pa ? raw : ident(op, se);
               end
               if (op == vhr_pkg::OP_FSEQ) begin
                  next_acc   = scalar_in & msk(se);
                  next_idx   = 5'h0;
                  next_state = vhr_pkg::ST_SEQ;
               end else begin
                  next_lvl   = 3'(vhr_pkg::LEVELS);
                  next_state = vhr_pkg::ST_TREE;
               end
            end
         end
         vhr_pkg::ST_TREE: begin
            // one level of the recursive pairwise tree per cycle
            for (int i = 0; i < vhr_pkg::LANES / 2; i++)
               next_work[i] = comb(cur_op, cur_esz, work[2 * i], work[2 * i + 1]);
            next_lvl = lvl - 3'h1;
            if (lvl == 3'h1) begin
               next_result = trim(cur_op, cur_esz, next_work[0]);
               next_done   = 1'b1;
               next_state  = vhr_pkg::ST_IDLE;
            end
         end
         vhr_pkg::ST_SEQ: begin
            // one lane per cycle, lowest first
            sum = act[idx] ? fp_add(acc, work[idx], cur_esz) : acc;
            next_acc = sum;
            next_idx = idx + 5'h1;
            if (idx == 5'((vhr_pkg::LANES >> cur_esz) - 1)) begin
               next_result = sum & msk(cur_esz);
               next_done   = 1'b1;
               next_state  = vhr_pkg::ST_IDLE;
            end
         end
         default: next_state = vhr_pkg::ST_IDLE;
      endcase
   end

   // registers only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state   <= vhr_pkg::ST_IDLE;
         cur_op  <= 4'h0;
         cur_esz <= 2'h0;
         act     <= 32'h0;
         acc     <= 64'h0;
         idx     <= 5'h0;
         lvl     <= 3'h0;
         result  <= vhr_pkg::RESULT_RST;
         done    <= 1'b0;
         for (int i = 0; i < vhr_pkg::LANES; i++)
            work[i] <= 64'h0;
      end else begin
         state   <= next_state;
         cur_op  <= next_op;
         cur_esz <= next_esz;
         act     <= next_act;
         acc     <= next_acc;
         idx     <= next_idx;
         lvl     <= next_lvl;
         result  <= next_result;
         done    <= next_done;
         for (int i = 0; i < vhr_pkg::LANES; i++)
            work[i] <= next_work[i];
      end
   end

   // busy while a reduction runs
   assign busy = (state != vhr_pkg::ST_IDLE);
endmodule : vhr_reduce
`default_nettype wire

// file: dv/vhr_reduce_props.sv
// Purpose: port timing and identity checks
// Assumes: sees only vhr_reduce ports, single core_clk domain
// Notes:   bind follows the module
`timescale 1ns/100ps
`default_nettype none
module vhr_reduce_props (
   input wire logic         core_clk,  // core clock
   input wire logic         rst_n,     // async reset, active low
   input wire logic         start,     // request strobe
   input wire logic [3:0]   op,        // operation code
   input wire logic [1:0]   esz,       // element size code
   input wire logic [31:0]  pred,      // governing predicate
   input wire logic         busy,      // engine working
   input wire logic         done,      // result pulse
   input wire logic [63:0]  result     // scalar result
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic take;  // request taken
   assign take = start && !busy;
   // all lanes dead gives the identity
   property p_ident(logic [3:0] o, logic [1:0] e, logic [63:0] v);
      take && pred == 32'h0 && op == o && esz == e |-> ##6 result == v;
   endproperty
   chk_tree_lat: assert property (take && op != vhr_pkg::OP_FSEQ |=> busy [*5] ##1 done)
      else $error("tree reduction late");
   chk_seq_lat_d: assert property (take && op == vhr_pkg::OP_FSEQ && esz == 2'h3 |=> busy [*4] ##1 done)
      else $error("four-lane ordered sum late");
   chk_seq_lat_b: assert property (take && op == vhr_pkg::OP_FSEQ && esz == 2'h1 |-> ##17 done)
      else $error("16-lane ordered sum late");
   chk_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   chk_result_hold: assert property (!done |-> $stable(result))
      else $error("result moved without done");
   chk_busy_cause: assert property ($rose(busy) |-> $past(start))
      else $error("busy rose without a request");
   chk_and_ident: assert property (p_ident(vhr_pkg::OP_AND, 2'h3, 64'hFFFF_FFFF_FFFF_FFFF))
      else $error("empty and reduction not all ones");
   chk_smax_ident: assert property (p_ident(vhr_pkg::OP_SMAX, 2'h1, 64'h0000_0000_0000_8000))
      else $error("empty signed max not most negative");
   chk_fmax_ident: assert property (p_ident(vhr_pkg::OP_FMAX, 2'h2, 64'h0000_0000_FF80_0000))
      else $error("empty fp max not negative infinity");
   chk_fmin_ident: assert property (p_ident(vhr_pkg::OP_FMIN, 2'h3, vhr_pkg::D_INF))
      else $error("empty fp min not positive infinity");
   chk_fmaxnm_ident: assert property (p_ident(vhr_pkg::OP_FMAXNM, 2'h1, vhr_pkg::H_DNAN))
      else $error("empty fp max-number not default NaN");
   // main scenarios reached
   cov_tree: cover property (take && op == vhr_pkg::OP_SADD);
   cov_seq: cover property (take && op == vhr_pkg::OP_FSEQ);
   cov_b2b: cover property (done && start);
endmodule : vhr_reduce_props
bind vhr_reduce vhr_reduce_props vhr_reduce_props_i (.core_clk(core_clk), .rst_n(rst_n),
   .start(start), .op(op), .esz(esz), .pred(pred), .busy(busy), .done(done), .result(result));
`default_nettype wire

// file: dv/vhr_issue_model.sv
// Purpose: issue-pipeline model presenting reduction requests
// Assumes: drives on falling edges only
// Notes:   optional junk strobes while busy probe refusal
`timescale 1ns/100ps
`default_nettype none
module vhr_issue_model (
   input  wire logic         core_clk,   // core clock
   input  wire logic         busy,       // engine working
   output var  logic         start,      // request strobe
   output var  logic [3:0]   op,         // operation code
   output var  logic [1:0]   esz,        // element size code
   output var  logic [255:0] src_vec,    // source vector
   output var  logic [31:0]  pred,       // governing predicate
   output var  logic [63:0]  scalar_in   // ordered sum seed
);
   // quiet lines at start
   initial begin
      start = 1'b0;
      op = 4'h0;
      esz = 2'h0;
      src_vec = '0;
      pred = '0;
      scalar_in = '0;
   end
   // hold a request until an idle edge takes it
   task automatic issue(input logic [3:0] o, input logic [1:0] e, input logic [255:0] v,
                        input logic [31:0] p, input logic [63:0] s, input bit junk);
      int n;
      @(negedge core_clk);
      start = 1'b1;
      op = o;
      esz = e;
      src_vec = v;
      pred = p;
      scalar_in = s;
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      // released lines show inverted values
      op = ~o;
      esz = ~e;
      src_vec = ~v;
      pred = ~p;
      scalar_in = ~s;
      start = junk;
      if (junk) begin
         repeat (2) @(negedge core_clk);  // strobes during busy
         start = 1'b0;
      end
   endtask : issue
endmodule : vhr_issue_model
`default_nettype wire

// file: dv/vhr_reduce_bench.sv
// Purpose: self-checking bench for the horizontal reduction unit
// Assumes: issue model drives requests, core clock 125 MHz
// Notes:   expectations queued, matched on done
`timescale 1ns/100ps
`default_nettype none
module vhr_reduce_bench;
   logic         core_clk;     // core clock
   logic         rst_n;        // reset, active low
   logic         start;        // request strobe
   logic [3:0]   op;           // operation code
   logic [1:0]   esz;          // element size code
   logic [255:0] src_vec;      // source vector
   logic [31:0]  pred;         // predicate
   logic [63:0]  scalar_in;    // ordered sum seed
   logic         busy;         // engine working
   logic         done;         // result pulse
   logic [63:0]  result;       // scalar result
   logic [63:0]  exp_q[$];     // pending expectations
   logic [63:0]  want;         // expectation under test
   logic [3:0]   o;            // scenario op
   logic [1:0]   e;            // scenario size
   logic [255:0] v;            // scenario vector
   logic [31:0]  p;            // scenario predicate
   logic [63:0]  s;            // scenario seed
   logic [63:0]  x;            // scenario value
   int           k;            // lane or wait count
   int           seed;         // random seed
   int           fail_count;   // mismatches
   int           checks_done;  // comparisons
   // free-running clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   vhr_issue_model vhr_issue_model_i (.core_clk(core_clk), .busy(busy), .start(start), .op(op),
      .esz(esz), .src_vec(src_vec), .pred(pred), .scalar_in(scalar_in));
   vhr_reduce vhr_reduce_i (.core_clk(core_clk), .rst_n(rst_n), .start(start), .op(op),
      .esz(esz), .src_vec(src_vec), .pred(pred), .scalar_in(scalar_in), .busy(busy),
      .done(done), .result(result));
   // element mask for a size code
   function automatic logic [63:0] emask(input logic [1:0] e);
      return (e == 2'h3) ? 64'hFFFF_FFFF_FFFF_FFFF : (64'h1 << (8 << e)) - 64'h1;
   endfunction : emask
   // integer reference from identity start
   function automatic logic [63:0] ref_int(input logic [3:0] o, input logic [1:0] e,
                                           input logic [255:0] v, input logic [31:0] p);
      logic [63:0] m, a, y;
      m = emask(e);
      case (o)
         vhr_pkg::OP_AND, vhr_pkg::OP_UMIN: a = m;
         vhr_pkg::OP_SMAX: a = ~(m >> 1);  // most negative
         vhr_pkg::OP_SMIN: a = m >> 1;
         default: a = 64'h0;
      endcase
      for (int i = 0; i < (32 >> e); i++) begin
         y = 64'(v >> (i * (8 << e))) & m;
         if (o inside {vhr_pkg::OP_SADD, vhr_pkg::OP_SMAX, vhr_pkg::OP_SMIN} && y[(8 << e) - 1])
            y = y | ~m;
         if (p[i << e]) begin  // lowest predicate bit of the lane
            case (o)
               vhr_pkg::OP_AND: a = a & y;
               vhr_pkg::OP_OR: a = a | y;
               vhr_pkg::OP_XOR: a = a ^ y;
               vhr_pkg::OP_SADD, vhr_pkg::OP_UADD: a = a + y;
               vhr_pkg::OP_SMAX: if ($signed(y) > $signed(a)) a = y;
               vhr_pkg::OP_SMIN: if ($signed(y) < $signed(a)) a = y;
               vhr_pkg::OP_UMAX: if (y > a) a = y;
               default: if (y < a) a = y;
            endcase
         end
      end
      return (o == vhr_pkg::OP_SADD || o == vhr_pkg::OP_UADD) ? a : a & m;
   endfunction : ref_int
   // fp identity, size code 1..3
   function automatic logic [63:0] fp_ident(input logic [3:0] o, input logic [1:0] e);
      logic [63:0] inf;
      inf = (e == 2'h3) ? vhr_pkg::D_INF : (e == 2'h2) ? vhr_pkg::S_INF : vhr_pkg::H_INF;
      case (o)
         vhr_pkg::OP_FMAX: return inf | (emask(e) ^ (emask(e) >> 1));  // negative infinity
         vhr_pkg::OP_FMIN: return inf;
         vhr_pkg::OP_FMAXNM, vhr_pkg::OP_FMINNM: return inf | (inf & ~(inf << 1)) >> 1;
         default: return 64'h0;
      endcase
   endfunction : fp_ident
   // random full-width vector
   function automatic logic [255:0] rvec();
      logic [255:0] r;
      for (int i = 0; i < 8; i++) r = {r[223:0], 32'($random(seed))};
      return r;
   endfunction : rvec
   // queue expectation, then issue
   task automatic send(input logic [63:0] want_v, input bit junk);
      exp_q.push_back(want_v);
      vhr_issue_model_i.issue(o, e, v, p, s, junk);
   endtask : send
   // counts, verdict, stop
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   // match each done to oldest note
   always @(negedge core_clk) begin
      if (rst_n === 1'b1 && done === 1'b1) begin
         checks_done++;
         want = (exp_q.size() != 0) ? exp_q.pop_front() : ~result;
         if (result !== want) begin
            fail_count++;
            $display("BAD %0t result %h expected %h", $time, result, want);
         end
      end
   end
   // cut a hang short
   initial begin
      #(8 * 20000);
      fail_count++;
      final_report();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      fail_count = 0;
      checks_done = 0;
      seed = 6251;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      // every op and size, all lanes dead
      for (int oi = 0; oi < 15; oi++) begin
         for (int ei = 0; ei < 4; ei++) begin
            o = 4'(oi);
            e = 2'(ei);
            v = rvec();
            p = 32'h0;
            s = {32'($random(seed)), 32'($random(seed))};
            k = (ei == 0) ? 1 : ei;  // fp size, 8-bit code acts as 16-bit
            x = (oi < 9) ? ref_int(o, e, v, p) : (o == vhr_pkg::OP_FSEQ) ? s & emask(2'(k))
                : fp_ident(o, 2'(k));
            send(x, ei == 1);
         end
      end
      // random integer reductions
      for (int i = 0; i < 60; i++) begin
         o = 4'($unsigned($random(seed)) % 9);
         e = 2'($random(seed));
         v = rvec();
         p = (i % 4 == 0) ? 32'hFFFF_FFFF : 32'($random(seed));
         send(ref_int(o, e, v, p), 1'b0);
      end
      // one live fp lane
      for (int i = 0; i < 18; i++) begin
         o = 4'(9 + i % 6);
         e = 2'(1 + (i / 6) % 3);
         k = $unsigned($random(seed)) % (32 >> e);
         x = {32'($random(seed)), 32'($random(seed))} & (emask(e) >> 2);  // positive finite
         v = rvec() & ~({192'h0, emask(e)} << (k * (8 << e)));
         p = 32'h1 << (k << e);
         s = x;
         if (o != vhr_pkg::OP_FSEQ) v = v | ({192'h0, x} << (k * (8 << e)));
         send(x, 1'b0);
      end
      // ordered sum: 2^24 + 1.0 + 1.0 rounds away each step, 1.0 seed gives 3.0
      for (int i = 0; i < 2; i++) begin
         o = vhr_pkg::OP_FSEQ;
         e = 2'h2;
         v = rvec();
         v[95:64] = 32'h3F80_0000;
         v[223:192] = 32'h3F80_0000;
         p = 32'h0100_0100;
         s = (i == 0) ? 64'h0000_0000_4B80_0000 : 64'h0000_0000_3F80_0000;
         send((i == 0) ? 64'h0000_0000_4B80_0000 : 64'h0000_0000_4040_0000, 1'b0);
      end
      k = 0;
      while (exp_q.size() != 0 && k < 200) begin
         @(negedge core_clk);
         k++;
      end
      if (exp_q.size() != 0) begin
         fail_count++;
         $display("BAD %0t results missing", $time);
      end
      final_report();
   end
endmodule : vhr_reduce_bench
`default_nettype wire
